// ### rtl/csc_pkg.sv
// constants, register map and types for the slot control register bank
package csc_pkg;
   // register offsets
   localparam logic [7:0] OFS_A_MASK_HI  = 8'h01;
   localparam logic [7:0] OFS_A_MASK_LO  = 8'h02;
   localparam logic [7:0] OFS_A_PAT_HI   = 8'h03;
   localparam logic [7:0] OFS_A_PAT_LO   = 8'h04;
   localparam logic [7:0] OFS_A_CYCLE    = 8'h05;
   localparam logic [7:0] OFS_B_MASK_HI  = 8'h0a;
   localparam logic [7:0] OFS_B_MASK_LO  = 8'h0b;
   localparam logic [7:0] OFS_B_PAT_HI   = 8'h0c;
   localparam logic [7:0] OFS_B_PAT_LO   = 8'h0d;
   localparam logic [7:0] OFS_B_CYCLE    = 8'h0e;
   localparam logic [7:0] OFS_X_MASK_HI  = 8'h12;
   localparam logic [7:0] OFS_X_MASK_LO  = 8'h13;
   localparam logic [7:0] OFS_X_PAT_HI   = 8'h14;
   localparam logic [7:0] OFS_X_PAT_LO   = 8'h15;
   localparam logic [7:0] OFS_DEST_SEL   = 8'h17;
   localparam logic [7:0] OFS_SUPPLY     = 8'h18;
   localparam logic [7:0] OFS_EVENTS     = 8'h1a;
   localparam logic [7:0] OFS_EVT_MASK   = 8'h1b;
   localparam logic [7:0] OFS_INT_CFG    = 8'h1c;
   // field positions
   localparam int BIT_SUPPLY_ON   = 0;
   localparam int BIT_SUPPLY_POL  = 6;
   localparam int BIT_SUPPLY_DRV  = 7;
   localparam int BIT_AUX_FALLBK  = 7;
   localparam int BIT_AUTO_ROUTE  = 0;
   localparam int BIT_XCS_POL     = 3;
   localparam int BIT_XCS_DRV     = 4;
   localparam int BIT_OUT_REQ_POL = 0;
   localparam int BIT_INT_POL     = 1;
   localparam int BIT_INT_DRV     = 2;
   // reset value shared by every writable register
   localparam logic [7:0] REG_RESET = 8'h00;
   // cycle times
   localparam int CLK_NS    = 5;
   localparam int T100_NS   = 100;
   localparam int T150_NS   = 150;
   localparam int T200_NS   = 200;
   localparam int T250_NS   = 250;
   localparam int T300_NS   = 300;
   localparam int T600_NS   = 600;
   localparam logic [7:0] CYC_100 = 8'((T100_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] CYC_150 = 8'((T150_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] CYC_200 = 8'((T200_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] CYC_250 = 8'((T250_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] CYC_300 = 8'((T300_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] CYC_600 = 8'((T600_NS + CLK_NS - 1) / CLK_NS);
   // module control bundle, all active low
   typedef struct packed {
      logic ce_a_n;
      logic ce_b_n;
      logic oe_n;
      logic we_n;
      logic reg_n;
   } csc_mod_ctl_t;
   localparam csc_mod_ctl_t MOD_CTL_IDLE = 5'h1f;
endpackage : csc_pkg

// ### rtl/csc_slot_ctrl.sv
// slot control register bank: power, window decode, cycle timing, events
`timescale 1ns/10ps
module csc_slot_ctrl
   import csc_pkg::*;
(
   input  wire logic         mclk,                  // system clock
   input  wire logic         nrst,                  // async reset, active low
   input  wire logic         ce,                    // clock enable
   input  wire logic         reg_wr,                // register write strobe
   input  wire logic         reg_rd,                // register read strobe
   input  wire logic [7:0]   reg_addr,              // register offset
   input  wire logic [7:0]   reg_wdata,             // write data
   output logic [7:0]        reg_rdata,             // read data
   input  wire logic         host_cs_n,             // host chip select pin
   input  wire logic         host_rd_n,             // host read strobe pin
   input  wire logic         host_wr_n,             // host write strobe pin
   input  wire logic         host_attr,             // attribute space access
   input  wire logic [10:0]  host_addr,             // host address 25:15
   input  wire logic         slot_a_detect_n,       // slot A card detect
   input  wire logic         slot_b_detect_n,       // slot B card detect
   input  wire logic         slot_a_request_n,      // slot A request line
   input  wire logic         slot_b_request_n,      // slot B request line
   input  wire logic         outside_request_input, // auxiliary request pin
   output logic              host_wait,             // stall host cycle
   output csc_mod_ctl_t      mod_ctl,               // module control strobes
   output logic              mod_ctl_oe,            // module controls driven
   output logic              address_buffer_oe_n,   // address buffer enable
   output logic              data_buffer_oe_n,      // data buffer enable
   output logic              supply_pin_out,        // supply switch level
   output logic              supply_pin_oe,         // supply switch enable
   output logic              aux_cs_out,            // aux chip select level
   output logic              aux_cs_oe,             // aux chip select enable
   output logic              int_pin_out,           // host interrupt level
   output logic              int_pin_oe             // host interrupt enable
);
   typedef enum logic [1:0] {S_IDLE, S_ACTIVE, S_RELEASE} csc_state_t;
   localparam int NSYNC = 20;

   logic              rst_meta;
   logic              rst_n;
   logic [NSYNC-1:0]  in_meta;
   logic [NSYNC-1:0]  in_sync;
   logic [2:0]        sync_fill;
   logic [7:0]        regs [0:31];
   logic [4:0]        ev_flags;
   logic [4:0]        ev_mask;
   logic [2:0]        int_cfg;
   logic              det_a_prev;
   logic              det_b_prev;
   logic              int_active;
   csc_state_t        state;
   logic [7:0]        cnt;
   logic [7:0]        load_len;
   logic [7:0]        act_len;
   logic              cur_slot_b;

   // synchronous release of the reset
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // every pin input passes two flops
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         in_meta   <= '0;
         in_sync   <= '0;
         sync_fill <= '0;
      end else if (ce) begin
         sync_fill <= {sync_fill[1:0], 1'b1};
         in_meta <= {outside_request_input, slot_b_request_n, slot_a_request_n, slot_b_detect_n,
                     slot_a_detect_n, host_addr, host_attr, host_wr_n, host_rd_n, host_cs_n};
         in_sync <= in_meta;
      end
   end

   logic        s_cs;
   logic        s_rd;
   logic        s_wr;
   logic        s_attr;
   logic [10:0] s_addr;
   logic        s_det_a;
   logic        s_det_b;
   logic        s_req_a;
   logic        s_req_b;
   logic        s_out_req;
   assign s_cs      = ~in_sync[0];
   assign s_rd      = ~in_sync[1];
   assign s_wr      = ~in_sync[2];
   assign s_attr    = in_sync[3];
   assign s_addr    = in_sync[14:4];
   assign s_det_a   = in_sync[15];
   assign s_det_b   = in_sync[16];
   assign s_req_a   = ~in_sync[17];
   assign s_req_b   = ~in_sync[18];
   assign s_out_req = in_sync[19];

   function automatic logic win_hit(input logic [7:0] hi_mask, input logic [7:0] lo_mask,
                                    input logic [7:0] hi_pat, input logic [7:0] lo_pat,
                                    input logic [10:0] addr);
      logic [10:0] m;
      logic [10:0] p;
      m = {hi_mask[2:0], lo_mask};
      p = {hi_pat[2:0], lo_pat};
      return &(~m | ~(addr ^ p));
   endfunction : win_hit

   function automatic logic [7:0] cyc_len(input logic [2:0] code, input logic attr, input logic wr);
      logic [7:0] n;
      n = CYC_600;
      if (attr && !wr)
         n = (code == 3'h4) ? CYC_600 : CYC_300;
      else begin
         case (code)
            3'h0:    n = CYC_100;
            3'h1:    n = CYC_150;
            3'h2:    n = CYC_200;
            3'h3:    n = CYC_250;
            default: n = CYC_600; // reserved codes run slowest, safest for the card
         endcase
      end
      return n;
   endfunction : cyc_len

   // register fields
   logic       pwr_on;
   logic       auto_en;
   logic [1:0] sel_field;
   logic       aux_def;
   assign pwr_on    = regs[OFS_SUPPLY[4:0]][BIT_SUPPLY_ON];
   assign auto_en   = regs[OFS_DEST_SEL[4:0]][BIT_AUTO_ROUTE];
   assign sel_field = regs[OFS_DEST_SEL[4:0]][2:1];
   assign aux_def   = regs[OFS_X_MASK_HI[4:0]][BIT_AUX_FALLBK];

   // destination decode
   logic hit_a;
   logic hit_b;
   logic hit_x;
   logic sel_a;
   logic sel_b;
   logic aux_sel;
   assign hit_a = win_hit(regs[OFS_A_MASK_HI[4:0]], regs[OFS_A_MASK_LO[4:0]],
                          regs[OFS_A_PAT_HI[4:0]], regs[OFS_A_PAT_LO[4:0]], s_addr);
   assign hit_b = win_hit(regs[OFS_B_MASK_HI[4:0]], regs[OFS_B_MASK_LO[4:0]],
                          regs[OFS_B_PAT_HI[4:0]], regs[OFS_B_PAT_LO[4:0]], s_addr);
   assign hit_x = win_hit(regs[OFS_X_MASK_HI[4:0]], regs[OFS_X_MASK_LO[4:0]],
                          regs[OFS_X_PAT_HI[4:0]], regs[OFS_X_PAT_LO[4:0]], s_addr);

   always_comb begin
      if (auto_en) begin
         sel_a   = hit_a;
         sel_b   = hit_b & ~hit_a; // overlapping windows favour slot A
         aux_sel = aux_def ? (s_cs & ~hit_a & ~hit_b) : (s_cs & hit_x);
      end else begin
         sel_a   = (sel_field == 2'h1);
         sel_b   = (sel_field == 2'h2);
         aux_sel = s_cs & (sel_field == 2'h3);
      end
   end

   // register file writes; status register is not writable
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 32; i++)
            regs[i] <= REG_RESET;
      end else if (ce && reg_wr && reg_addr[7:5] == 3'h0 && reg_addr != OFS_EVENTS) begin
         regs[reg_addr[4:0]] <= reg_wdata;
      end
   end
   assign ev_mask = regs[OFS_EVT_MASK[4:0]][4:0];
   assign int_cfg = regs[OFS_INT_CFG[4:0]][2:0];

   // event flags: moves latch, request levels follow the lines
   logic det_evt_a;
   logic det_evt_b;
   logic rd_events;
   logic out_act;
   // no move until the detect history holds real pin samples, else reset fakes one
   assign det_evt_a = sync_fill[2] & (s_det_a ^ det_a_prev);
   assign det_evt_b = sync_fill[2] & (s_det_b ^ det_b_prev);
   assign rd_events = reg_rd && reg_addr == OFS_EVENTS;
   assign out_act   = ~(s_out_req ^ int_cfg[BIT_OUT_REQ_POL]);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         det_a_prev <= 1'b1;
         det_b_prev <= 1'b1;
         ev_flags   <= '0;
      end else if (ce) begin
         det_a_prev  <= s_det_a;
         det_b_prev  <= s_det_b;
         // a move arriving with the clearing read is kept
         ev_flags[0] <= det_evt_a | (ev_flags[0] & ~rd_events);
         ev_flags[1] <= det_evt_b | (ev_flags[1] & ~rd_events);
         ev_flags[2] <= s_req_a;
         ev_flags[3] <= s_req_b;
         ev_flags[4] <= out_act;
      end
   end

   // register read port
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         reg_rdata <= '0;
      else if (ce && reg_rd) begin
         if (reg_addr == OFS_EVENTS)
            reg_rdata <= {3'h0, ev_flags};
         else if (reg_addr[7:5] == 3'h0)
            reg_rdata <= regs[reg_addr[4:0]];
         else
            reg_rdata <= 8'h00;
      end
   end

   // interrupt pin
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         int_active  <= 1'b0;
         int_pin_out <= 1'b1;
         int_pin_oe  <= 1'b0;
      end else if (ce) begin
         int_active  <= |(ev_flags & ev_mask);
         int_pin_out <= ~(|(ev_flags & ev_mask) ^ int_cfg[BIT_INT_POL]);
         int_pin_oe  <= int_cfg[BIT_INT_DRV] | ~(~(|(ev_flags & ev_mask) ^ int_cfg[BIT_INT_POL]));
      end
   end

   // supply switch and aux select pins
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         supply_pin_out <= 1'b0;
         supply_pin_oe  <= 1'b0;
         aux_cs_out     <= 1'b1;
         aux_cs_oe      <= 1'b0;
      end else if (ce) begin
         supply_pin_out <= ~(pwr_on ^ regs[OFS_SUPPLY[4:0]][BIT_SUPPLY_POL]);
         supply_pin_oe  <= regs[OFS_SUPPLY[4:0]][BIT_SUPPLY_DRV] |
                           (pwr_on ^ regs[OFS_SUPPLY[4:0]][BIT_SUPPLY_POL]);
         aux_cs_out     <= ~(aux_sel ^ regs[OFS_DEST_SEL[4:0]][BIT_XCS_POL]);
         aux_cs_oe      <= regs[OFS_DEST_SEL[4:0]][BIT_XCS_DRV] |
                           (aux_sel ^ regs[OFS_DEST_SEL[4:0]][BIT_XCS_POL]);
      end
   end

   // slot access sequencer
   logic       strobe;
   logic       start;
   logic [7:0] next_len;
   logic [7:0] cyc_reg;
   assign strobe   = s_rd | s_wr;
   assign start    = state == S_IDLE && pwr_on && s_cs && strobe && (sel_a | sel_b);
   assign cyc_reg  = sel_b ? regs[OFS_B_CYCLE[4:0]] : regs[OFS_A_CYCLE[4:0]];
   assign next_len = cyc_len(s_attr ? cyc_reg[6:4] : cyc_reg[2:0], s_attr, s_wr);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state      <= S_IDLE;
         cnt        <= '0;
         load_len   <= '0;
         cur_slot_b <= 1'b0;
         host_wait  <= 1'b0;
         mod_ctl    <= MOD_CTL_IDLE;
      end else if (ce) begin
         case (state)
            S_IDLE: begin
               if (start) begin
                  state          <= S_ACTIVE;
                  cnt            <= next_len;
                  load_len       <= next_len;
                  cur_slot_b     <= sel_b;
                  host_wait      <= 1'b1;
                  mod_ctl.ce_a_n <= sel_b;
                  mod_ctl.ce_b_n <= ~sel_b;
                  mod_ctl.oe_n   <= ~s_rd;
                  mod_ctl.we_n   <= s_rd;
                  mod_ctl.reg_n  <= ~s_attr;
               end
            end
            S_ACTIVE: begin
               cnt <= cnt - 8'h01;
               if (cnt == 8'h01 || !pwr_on) begin
                  state     <= S_RELEASE;
                  host_wait <= 1'b0;
                  mod_ctl   <= MOD_CTL_IDLE;
               end
            end
            S_RELEASE: begin
               // the host must drop its strobe before another cycle starts
               if (!strobe)
                  state <= S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // slot-side drivers and external buffers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mod_ctl_oe          <= 1'b0;
         address_buffer_oe_n <= 1'b1;
         data_buffer_oe_n    <= 1'b1;
      end else if (ce) begin
         mod_ctl_oe          <= pwr_on;
         address_buffer_oe_n <= ~pwr_on;
         data_buffer_oe_n    <= ~(pwr_on && (start || state == S_ACTIVE));
      end
   end

   // helper: cycles spent in the active phase
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         act_len <= '0;
      else if (ce)
         act_len <= (state == S_ACTIVE) ? act_len + 8'h01 : 8'h00;
   end

   a_power_float: assert property (@(posedge mclk) disable iff (!rst_n)
      (ce && !pwr_on) |=> !mod_ctl_oe) else $error("slot drivers on while power off");
   a_buffers_float: assert property (@(posedge mclk) disable iff (!rst_n)
      (ce && !pwr_on) |=> (address_buffer_oe_n && data_buffer_oe_n)) else $error("buffer enabled while power off");
   a_manual_route: assert property (@(posedge mclk) disable iff (!rst_n)
      (!auto_en && sel_field != 2'h1) |-> !sel_a) else $error("slot A chosen outside manual select");
   a_aux_match: assert property (@(posedge mclk) disable iff (!rst_n)
      (auto_en && !aux_def && s_cs) |-> (aux_sel == hit_x)) else $error("aux select ignores window");
   a_aux_fallback: assert property (@(posedge mclk) disable iff (!rst_n)
      (auto_en && aux_def) |-> (aux_sel == (s_cs && !sel_a && !sel_b))) else $error("aux fallback wrong");
   a_wait_held: assert property (@(posedge mclk) disable iff (!rst_n)
      (state == S_ACTIVE) |-> (host_wait && (mod_ctl.ce_a_n != mod_ctl.ce_b_n))) else $error("host not stalled");
   a_cycle_length: assert property (@(posedge mclk) disable iff (!rst_n)
      (ce && state == S_ACTIVE && cnt == 8'h01 && pwr_on) |-> (act_len + 8'h01 == load_len))
      else $error("module cycle length wrong");
   a_attr_read_len: assert property (@(posedge mclk) disable iff (!rst_n)
      (ce && start && s_attr && !s_wr) |=> (load_len == CYC_600 || load_len == CYC_300)) else $error("attr read len");
   a_move_kept: assert property (@(posedge mclk) disable iff (!rst_n)
      (ce && det_evt_a) |=> ev_flags[0]) else $error("slot A move lost");
   a_int_follow: assert property (@(posedge mclk) disable iff (!rst_n)
      (ce && |(ev_flags & ev_mask)) |=> int_active) else $error("interrupt not raised");
endmodule : csc_slot_ctrl

// ### testbench/csc_card_model.sv
// behavioural model of the two card slots: detect, request and strobe timing
`timescale 1ns/10ps
module csc_card_model
   import csc_pkg::*;
(
   input  wire logic         mclk,             // system clock
   input  wire csc_mod_ctl_t mod_ctl,          // strobes from the block
   input  wire logic         mod_ctl_oe,       // strobes driven
   input  wire logic [1:0]   present,          // cards seated, bit 1 slot B
   input  wire logic [1:0]   request,          // cards requesting, bit 1 slot B
   output logic              slot_a_detect_n,  // slot A detect line
   output logic              slot_b_detect_n,  // slot B detect line
   output logic              slot_a_request_n, // slot A request line
   output logic              slot_b_request_n, // slot B request line
   output logic [7:0]        strobe_len,       // length of last card cycle
   output logic              last_b            // last cycle went to slot B
);
   csc_mod_ctl_t seen;
   logic [7:0]   run = 8'h00;
   // undriven strobes read as the pull-up level, never the last value
   assign seen = mod_ctl_oe ? mod_ctl : MOD_CTL_IDLE;
   assign slot_a_detect_n  = ~present[0];
   assign slot_b_detect_n  = ~present[1];
   assign slot_a_request_n = ~request[0];
   assign slot_b_request_n = ~request[1];
   initial strobe_len = 8'h00;
   initial last_b = 1'b0;
   always @(posedge mclk) begin
      if (!seen.ce_a_n || !seen.ce_b_n) begin
         run    <= run + 8'h01;
         last_b <= !seen.ce_b_n;
      end else if (run != 8'h00) begin
         strobe_len <= run;
         run        <= 8'h00;
      end
   end
endmodule : csc_card_model

// ### testbench/testbench.sv
// self-checking bench for the slot control register bank
`timescale 1ns/10ps
module testbench
   import csc_pkg::*;
;
   logic         mclk, nrst, ce, reg_wr, reg_rd, host_cs_n, host_rd_n, host_wr_n, host_attr;
   logic         outside_request_input, host_wait, mod_ctl_oe, address_buffer_oe_n, data_buffer_oe_n;
   logic         supply_pin_out, supply_pin_oe, aux_cs_out, aux_cs_oe, int_pin_out, int_pin_oe;
   logic         slot_a_detect_n, slot_b_detect_n, slot_a_request_n, slot_b_request_n, last_b;
   logic [7:0]   reg_addr, reg_wdata, reg_rdata, rd_val, strobe_len;
   logic [10:0]  host_addr;
   logic [1:0]   present, request, k;
   csc_mod_ctl_t mod_ctl;
   int           errors, checked;
   logic [7:0]   cyc [5] = '{CYC_100, CYC_150, CYC_200, CYC_250, CYC_600};
   logic [7:0]   ofs [14] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h12, 8'h13,
                              8'h14, 8'h15, 8'h18, 8'h1b};

   csc_slot_ctrl i_csc_slot_ctrl (.mclk(mclk), .nrst(nrst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .host_cs_n(host_cs_n),
      .host_rd_n(host_rd_n), .host_wr_n(host_wr_n), .host_attr(host_attr), .host_addr(host_addr),
      .slot_a_detect_n(slot_a_detect_n), .slot_b_detect_n(slot_b_detect_n),
      .slot_a_request_n(slot_a_request_n), .slot_b_request_n(slot_b_request_n),
      .outside_request_input(outside_request_input), .host_wait(host_wait), .mod_ctl(mod_ctl),
      .mod_ctl_oe(mod_ctl_oe), .address_buffer_oe_n(address_buffer_oe_n),
      .data_buffer_oe_n(data_buffer_oe_n), .supply_pin_out(supply_pin_out), .supply_pin_oe(supply_pin_oe),
      .aux_cs_out(aux_cs_out), .aux_cs_oe(aux_cs_oe), .int_pin_out(int_pin_out), .int_pin_oe(int_pin_oe));

   csc_card_model i_csc_card_model (.mclk(mclk), .mod_ctl(mod_ctl), .mod_ctl_oe(mod_ctl_oe),
      .present(present), .request(request), .slot_a_detect_n(slot_a_detect_n),
      .slot_b_detect_n(slot_b_detect_n), .slot_a_request_n(slot_a_request_n),
      .slot_b_request_n(slot_b_request_n), .strobe_len(strobe_len), .last_b(last_b));

   task automatic report_and_stop;
      if (errors == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : report_and_stop

   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp8

   task automatic cmp1(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp1

   task automatic wait_cycles(input int n);
      repeat (n) @(negedge mclk);
   endtask : wait_cycles

   // each access starts one edge after entry so strobes never toggle twice at once
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask : reg_write

   task automatic reg_check(input logic [7:0] a, input logic [7:0] exp);
      @(negedge mclk);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge mclk);
      reg_rd = 1'b0;
      cmp8(reg_rdata, exp);
   endtask : reg_check

   // exp of zero means the block must leave the host cycle alone
   task automatic host_access(input logic [10:0] a, input logic attr, input logic wr, input logic [7:0] exp);
      int n;
      @(negedge mclk);
      host_addr = a;
      host_attr = attr;
      host_cs_n = 1'b0;
      host_rd_n = wr;
      host_wr_n = !wr;
      n = 0;
      while (host_wait !== 1'b1 && n < 20) begin
         @(negedge mclk);
         n++;
      end
      if (n == 20 && exp != 8'h00) begin
         errors++;
         report_and_stop();
      end
      n = 0;
      while (host_wait === 1'b1 && n < 250) begin
         n++;
         @(negedge mclk);
      end
      host_cs_n = 1'b1;
      host_rd_n = 1'b1;
      host_wr_n = 1'b1;
      wait_cycles(4);
      cmp8(8'(n), exp);
      if (exp != 8'h00) cmp8(strobe_len, exp);
   endtask : host_access

   task automatic aux_probe(input logic [10:0] a, input logic exp);
      @(negedge mclk);
      host_addr = a;
      host_cs_n = 1'b0;
      wait_cycles(6);
      cmp1(aux_cs_oe, exp);
      if (exp) cmp1(aux_cs_out, 1'b0);
      host_cs_n = 1'b1;
      wait_cycles(6);
   endtask : aux_probe

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   initial begin
      nrst = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
      host_cs_n = 1'b1; host_rd_n = 1'b1; host_wr_n = 1'b1; host_attr = 1'b0; host_addr = 11'h000;
      outside_request_input = 1'b1; present = 2'b11; request = 2'b00;
      errors = 0; checked = 0;
      ce = 1'b1;
      wait_cycles(20);
      nrst = 1'b1;
      wait_cycles(4);
      cmp1(mod_ctl_oe, 1'b0);
      cmp1(address_buffer_oe_n, 1'b1);
      cmp1(data_buffer_oe_n, 1'b1);
      foreach (ofs[i]) begin
         reg_write(ofs[i], 8'h5a ^ ofs[i]);
         reg_check(ofs[i], 8'h5a ^ ofs[i]);
      end
      // a write while the clock enable is low must leave the register alone
      ce = 1'b0;
      reg_write(OFS_A_MASK_LO, 8'hff);
      ce = 1'b1;
      reg_check(OFS_A_MASK_LO, 8'h58);
      reg_write(OFS_EVT_MASK, 8'h00);
      reg_check(OFS_EVENTS, 8'h00);
      reg_write(OFS_EVENTS, 8'hff);
      reg_check(OFS_EVENTS, 8'h00);
      for (int i = 0; i < 4; i++) begin
         k = 2'(i);
         reg_write(OFS_SUPPLY, {k, 6'h01});
         wait_cycles(2);
         cmp1(supply_pin_oe, k[1] | ~k[0]);
         if (k[1] | ~k[0]) cmp1(supply_pin_out, k[0]);
      end
      cmp1(mod_ctl_oe, 1'b1);
      cmp1(address_buffer_oe_n, 1'b0);
      reg_write(OFS_DEST_SEL, 8'h02);
      for (int i = 0; i < 5; i++) begin
         reg_write(OFS_A_CYCLE, 8'(i));
         host_access(11'h000, 1'b0, 1'b1, cyc[i]);
         cmp1(last_b, 1'b0);
      end
      reg_write(OFS_A_CYCLE, 8'h30);
      host_access(11'h000, 1'b1, 1'b0, CYC_300);
      host_access(11'h000, 1'b1, 1'b1, CYC_250);
      reg_write(OFS_A_CYCLE, 8'h40);
      host_access(11'h000, 1'b1, 1'b0, CYC_600);
      host_access(11'h000, 1'b1, 1'b1, CYC_600);
      reg_write(OFS_A_CYCLE, 8'h10);
      reg_write(OFS_DEST_SEL, 8'h04);
      reg_write(OFS_B_CYCLE, 8'h02);
      host_access(11'h000, 1'b0, 1'b0, CYC_200);
      cmp1(last_b, 1'b1);
      reg_write(OFS_A_MASK_HI, 8'h04);
      reg_write(OFS_A_MASK_LO, 8'h00);
      reg_write(OFS_A_PAT_HI, 8'h04);
      reg_write(OFS_A_PAT_LO, 8'h00);
      reg_write(OFS_B_MASK_HI, 8'h06);
      reg_write(OFS_B_MASK_LO, 8'h00);
      reg_write(OFS_B_PAT_HI, 8'h02);
      reg_write(OFS_B_PAT_LO, 8'h00);
      reg_write(OFS_X_MASK_HI, 8'h01);
      reg_write(OFS_X_MASK_LO, 8'h01);
      reg_write(OFS_X_PAT_HI, 8'h01);
      reg_write(OFS_X_PAT_LO, 8'h01);
      host_access(11'h400, 1'b0, 1'b0, CYC_200);
      cmp1(last_b, 1'b1);
      reg_write(OFS_DEST_SEL, 8'h01);
      host_access(11'h5ff, 1'b0, 1'b0, CYC_100);
      cmp1(last_b, 1'b0);
      host_access(11'h200, 1'b0, 1'b1, CYC_200);
      cmp1(last_b, 1'b1);
      host_access(11'h101, 1'b0, 1'b0, 8'h00);
      aux_probe(11'h101, 1'b1);
      aux_probe(11'h100, 1'b0);
      reg_write(OFS_X_MASK_HI, 8'h80);
      aux_probe(11'h100, 1'b1);
      aux_probe(11'h400, 1'b0);
      reg_write(OFS_SUPPLY, 8'hc0);
      wait_cycles(2);
      cmp1(mod_ctl_oe, 1'b0);
      cmp1(address_buffer_oe_n, 1'b1);
      host_access(11'h400, 1'b0, 1'b0, 8'h00);
      cmp1(data_buffer_oe_n, 1'b1);
      reg_write(OFS_EVT_MASK, 8'h1f);
      reg_write(OFS_INT_CFG, 8'h07);
      outside_request_input = 1'b0;
      wait_cycles(4);
      cmp1(int_pin_out, 1'b0);
      present[0] = 1'b0;
      wait_cycles(6);
      cmp1(int_pin_out, 1'b1);
      reg_check(OFS_EVENTS, 8'h01);
      reg_check(OFS_EVENTS, 8'h00);
      present[1] = 1'b0;
      wait_cycles(6);
      reg_check(OFS_EVENTS, 8'h02);
      request = 2'b01;
      wait_cycles(6);
      reg_check(OFS_EVENTS, 8'h04);
      request = 2'b11;
      outside_request_input = 1'b1;
      wait_cycles(6);
      reg_check(OFS_EVENTS, 8'h1c);
      reg_write(OFS_INT_CFG, 8'h01);
      wait_cycles(3);
      cmp1(int_pin_oe, 1'b1);
      cmp1(int_pin_out, 1'b0);
      reg_write(OFS_EVT_MASK, 8'h00);
      wait_cycles(3);
      cmp1(int_pin_oe, 1'b0);
      report_and_stop();
   end
endmodule : testbench
